// File: design/mcpc_memclk_pll_control.sv
// Memory clock PLL control: divider registers, lock status, clock control register.
// Assumes host accesses on clk, analog PLL outside, loop N value from same clock.
`default_nettype none

// Behaviour
// R01: Software writes fixed bits of N, M and P registers with defined constants.
// R02: Software keeps N in 40..62, M in 1..62, P in 0..3.
// R03: Oscillator runs at 8 x reference x (65-M)/(65-N).
// R04: PLL output is the oscillator frequency divided by 2 to the P.
// R05: P bit 7 low holds the PLL in reset; high lets it oscillate.
// R06: Status bit 6 reads 1 once locked; other status bits undefined.
// R07: Software keeps memory clock output at or below 100 MHz.
// R08: Clock control register at index 0x39, resets 0x18, bit 7 reads 0.
// R09: Control bits 6:5 select reference output: pixel, loop, dot/N, reserved.
// R10: Dot/N output is a one-cycle low pulse every 65-N loop cycles.
// R11: Control bit 4 picks memory clock pin source: 0 dot, 1 PLL.
// R12: Pin source changes only on a 0-to-1 strobe of bit 3; bit 3 resets 1.
// R13: Software never changes bit 4 in the write that raises the strobe.
// R14: Control bits 2:0 hold loop post-scaler Q, divide by 2(Q+1), default 0.
// R15: After reset the memory clock PLL gives 50.11 MHz from 14.31818 MHz.
// R16: Software first moves pixel PLL to the target frequency and selects it.
// R17: Software then routes dot clock to the pin with 0,0 then 0,1.
// R18: Software then reprograms the memory clock PLL and polls for lock.
// R19: Software then restores the PLL to the pin with 1,0 then 1,1.
// R20: Software finally restores the pixel PLL and polls for lock.
// R21: Pointer bits 3:2 select N, M, P or read-only status for the data port.
// R22: Pointer advances after each data port write and holds on reads.
// R23: Lock flag reads 0 while the PLL is held in reset by its enable.
module mcpc_memclk_pll_control
  import mcpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_index,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       memclk_pll_locked_raw,
  input  wire logic [5:0] loop_n_value,
  output logic      [5:0] pll_n_div,
  output logic      [5:0] pll_m_div,
  output logic      [1:0] pll_p_div,
  output logic            pll_run_enable,
  output logic            memclk_pll_locked,
  output logic      [1:0] pll_pointer_register,
  output logic      [1:0] refout_source_sel,
  output logic            memclk_pin_source_sel,
  output logic      [2:0] loop_post_q,
  output logic            refout_divided_n
);

  mcpc_state_type st_reg;
  mcpc_state_type st_next;
  logic           lock_flag;
  logic           strobe_rise;
  logic [6:0]     div_last;

  // Lock from the analog macro only counts while the PLL is out of reset
  assign lock_flag = st_reg.lock_s2 & st_reg.p[P_ENABLE_BIT]; // [R06] [R23]
  assign div_last  = DIV_BASE - DIV_ONE - {1'b0, loop_n_value};

  always_comb
  begin
    st_next         = st_reg;
    strobe_rise     = 1'b0;
    st_next.lock_s1 = memclk_pll_locked_raw;
    st_next.lock_s2 = st_reg.lock_s1;

    if (reg_wr)
    begin
      unique case (reg_index)
        IDX_PLL_POINTER:
        begin
          st_next.ptr = reg_wdata[PTR_LSB+1:PTR_LSB]; // [R21]
        end
        IDX_MEMCLK_DATA:
        begin
          unique case (st_reg.ptr)
            PTR_N:      st_next.n = reg_wdata; // [R21]
            PTR_M:      st_next.m = reg_wdata; // [R21]
            PTR_P:      st_next.p = reg_wdata; // [R21]
            PTR_STATUS: st_next.p = st_reg.p;
          endcase
          // Pointer wraps from status back to N so N, M, P can be streamed again
          st_next.ptr = st_reg.ptr + 2'h1; // [R22]
        end
        IDX_CLOCK_CONTROL:
        begin
          st_next.ctrl = reg_wdata & CTRL_WRITE_MASK; // [R08]
          strobe_rise  = reg_wdata[CTRL_STROBE_BIT] & ~st_reg.ctrl[CTRL_STROBE_BIT];
          // The pin mux only moves on the strobe edge, so a select change alone is held
          if (strobe_rise)
          begin
            st_next.pin_sel = reg_wdata[CTRL_SEL_BIT]; // [R11] [R12]
          end
        end
        default:
        begin
          st_next.ptr = st_reg.ptr;
        end
      endcase
    end

    if (reg_rd)
    begin
      unique case (reg_index)
        IDX_PLL_POINTER:
        begin
          st_next.rdata = 8'h00;
          st_next.rdata[PTR_LSB+1:PTR_LSB] = st_reg.ptr;
        end
        IDX_MEMCLK_DATA:
        begin
          unique case (st_reg.ptr)
            PTR_N:   st_next.rdata = st_reg.n;
            PTR_M:   st_next.rdata = st_reg.m;
            PTR_P:   st_next.rdata = st_reg.p;
            PTR_STATUS:
            begin
              st_next.rdata = 8'h00;
              st_next.rdata[STATUS_LOCK_BIT] = lock_flag; // [R06]
            end
          endcase
        end
        IDX_CLOCK_CONTROL:
        begin
          st_next.rdata = st_reg.ctrl; // [R08]
        end
        default:
        begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // Dot clock prescaler, run only while selected so it starts in a known phase
    if (st_reg.ctrl[REFSEL_LSB+1:REFSEL_LSB] == REFSEL_DOTDIV)
    begin
      if (st_reg.div_cnt >= div_last)
      begin
        st_next.div_cnt  = 7'h00;
        st_next.refdiv_n = 1'b0; // [R10]
      end
      else
      begin
        st_next.div_cnt  = st_reg.div_cnt + 7'h01;
        st_next.refdiv_n = 1'b1;
      end
    end
    else
    begin
      st_next.div_cnt  = 7'h00;
      st_next.refdiv_n = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= MCPC_STATE_RESET; // [R15] [R08] [R12]
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // The analog macro turns these into f = 8*ref*(65-M)/(65-N)/2^P
  assign pll_n_div             = st_reg.n[DIV_MSB:0]; // [R03]
  assign pll_m_div             = st_reg.m[DIV_MSB:0]; // [R03]
  assign pll_p_div             = st_reg.p[P_MSB:0]; // [R04]
  assign pll_run_enable        = st_reg.p[P_ENABLE_BIT]; // [R05]
  assign memclk_pll_locked     = lock_flag;
  assign pll_pointer_register  = st_reg.ptr;
  assign refout_source_sel     = st_reg.ctrl[REFSEL_LSB+1:REFSEL_LSB]; // [R09]
  assign memclk_pin_source_sel = st_reg.pin_sel; // [R11]
  assign loop_post_q           = st_reg.ctrl[Q_LSB+2:Q_LSB]; // [R14]
  assign refout_divided_n      = st_reg.refdiv_n;
  assign reg_rdata             = st_reg.rdata;

  a_strobe_takes_sel: assert property ( // [R12]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_CLOCK_CONTROL && reg_wdata[CTRL_STROBE_BIT]
      && !st_reg.ctrl[CTRL_STROBE_BIT])
    |=> memclk_pin_source_sel == $past(reg_wdata[CTRL_SEL_BIT]))
    else $error("pin source not taken on strobe edge");

  a_sel_holds_nostrobe: assert property ( // [R12]
    @(posedge clk) disable iff (srst)
    !strobe_rise |=> $stable(memclk_pin_source_sel))
    else $error("pin source moved without strobe edge");

  a_ctrl_reserved_zero: assert property ( // [R08]
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_index == IDX_CLOCK_CONTROL) |=> !reg_rdata[7])
    else $error("control bit 7 read nonzero");

  a_ctrl_reset_value: assert property ( // [R08]
    @(posedge clk)
    $fell(srst) |-> (st_reg.ctrl == CTRL_RESET && memclk_pin_source_sel
      && pll_run_enable && loop_post_q == 3'h0))
    else $error("control reset value wrong");

  a_pointer_advance: assert property ( // [R22]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_MEMCLK_DATA)
    |=> pll_pointer_register == 2'($past(pll_pointer_register) + 2'h1))
    else $error("pointer did not advance after data write");

  a_pointer_read_hold: assert property ( // [R22]
    @(posedge clk) disable iff (srst)
    (reg_rd && !reg_wr) |=> $stable(pll_pointer_register))
    else $error("pointer moved on a read");

  a_divider_write: assert property ( // [R21]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_M)
    |=> pll_m_div == $past(reg_wdata[DIV_MSB:0]) ##1 $stable(pll_m_div))
    else $error("M divider not written through pointer");

  a_lock_gated: assert property ( // [R23]
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_STATUS
      && !pll_run_enable) |=> reg_rdata == 8'h00)
    else $error("lock read high while PLL held in reset");

  a_lock_sync_delay: assert property ( // [R06]
    @(posedge clk) disable iff (srst)
    (memclk_pll_locked_raw && pll_run_enable)[*3] |-> memclk_pll_locked)
    else $error("lock flag late");

  a_refout_pulse_width: assert property ( // [R10]
    @(posedge clk) disable iff (srst)
    (!refout_divided_n && $stable(loop_n_value) && loop_n_value < 6'h3E)
    |=> refout_divided_n ##1 refout_divided_n)
    else $error("dot/N pulse wider than one cycle");

  // Register map: each write lands where index and pointer say, and reads never disturb state
  a_ptr_write_lands: assert property ( // [R21]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_PLL_POINTER)
    |=> pll_pointer_register == $past(reg_wdata[PTR_LSB+1:PTR_LSB]))
    else $error("pointer write not taken");

  a_ptr_read_shows: assert property ( // [R22]
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_index == IDX_PLL_POINTER)
    |=> reg_rdata == {4'h0, $past(pll_pointer_register), 2'h0})
    else $error("pointer read back wrong");

  a_n_write_lands: assert property ( // [R21]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_N)
    |=> pll_n_div == $past(reg_wdata[DIV_MSB:0]))
    else $error("N divider not written through pointer");

  a_p_write_lands: assert property ( // [R05]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_P)
    |=> (pll_p_div == $past(reg_wdata[P_MSB:0])
      && pll_run_enable == $past(reg_wdata[P_ENABLE_BIT])))
    else $error("P value or enable not written through pointer");

  a_status_write_inert: assert property ( // [R21]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_STATUS)
    |=> ($stable(pll_n_div) && $stable(pll_m_div) && $stable(pll_p_div)
      && $stable(pll_run_enable)))
    else $error("write to status changed a divider");

  a_status_lock_read: assert property ( // [R06]
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_index == IDX_MEMCLK_DATA && pll_pointer_register == PTR_STATUS)
    |=> reg_rdata == {1'b0, $past(memclk_pll_locked), 6'h00})
    else $error("status read does not mirror lock flag");

  // Two-flop synchroniser: a lost lock shows up two edges late, never later
  a_lock_drops: assert property ( // [R06]
    @(posedge clk) disable iff (srst)
    (!memclk_pll_locked_raw ##1 !memclk_pll_locked_raw) |=> !memclk_pll_locked)
    else $error("lock flag held without raw lock");

  a_ctrl_fields_write: assert property ( // [R09] [R14]
    @(posedge clk) disable iff (srst)
    (reg_wr && reg_index == IDX_CLOCK_CONTROL)
    |=> (refout_source_sel == $past(reg_wdata[REFSEL_LSB+1:REFSEL_LSB])
      && loop_post_q == $past(reg_wdata[Q_LSB+2:Q_LSB])))
    else $error("control fields not written");

  a_refout_idle_high: assert property ( // [R10]
    @(posedge clk) disable iff (srst)
    (refout_source_sel != REFSEL_DOTDIV) |=> refout_divided_n)
    else $error("dot/N output pulsed while not selected");

  a_unmapped_read_zero: assert property ( // [R08]
    @(posedge clk) disable iff (srst)
    (reg_rd && reg_index != IDX_PLL_POINTER && reg_index != IDX_MEMCLK_DATA
      && reg_index != IDX_CLOCK_CONTROL) |=> reg_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

endmodule : mcpc_memclk_pll_control

`default_nettype wire

// File: design/mcpc_pkg.sv
// Constants and state type for the memory clock PLL control block.
// Assumes an indexed 8-bit host register port on the device clock.
`default_nettype none

package mcpc_pkg;

  localparam logic [7:0] IDX_PLL_POINTER   = 8'h2C;
  localparam logic [7:0] IDX_MEMCLK_DATA   = 8'h2E;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h39;

  localparam logic [1:0] PTR_N      = 2'h0;
  localparam logic [1:0] PTR_M      = 2'h1;
  localparam logic [1:0] PTR_P      = 2'h2;
  localparam logic [1:0] PTR_STATUS = 2'h3;
  localparam int         PTR_LSB    = 2;

  localparam logic [7:0] CTRL_RESET      = 8'h18;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;
  localparam int         CTRL_STROBE_BIT = 3;
  localparam int         CTRL_SEL_BIT    = 4;
  localparam int         REFSEL_LSB      = 5;
  localparam int         Q_LSB           = 0;

  localparam logic [1:0] REFSEL_PIXEL  = 2'h0;
  localparam logic [1:0] REFSEL_LOOP   = 2'h1;
  localparam logic [1:0] REFSEL_DOTDIV = 2'h2;

  localparam int         P_ENABLE_BIT    = 7;
  localparam int         STATUS_LOCK_BIT = 6;
  localparam int         DIV_MSB         = 5;
  localparam int         P_MSB           = 1;

  // Reset dividers: N=57, M=58, P=1 give 8*14.31818*7/8/2 = 50.11 MHz
  localparam logic [7:0] N_RESET = 8'hF9;
  localparam logic [7:0] M_RESET = 8'h3A;
  localparam logic [7:0] P_RESET = 8'hB1;

  localparam logic [6:0] DIV_BASE = 7'h41;
  localparam logic [6:0] DIV_ONE  = 7'h01;

  typedef struct packed {
    logic [1:0] ptr;
    logic [7:0] n;
    logic [7:0] m;
    logic [7:0] p;
    logic [7:0] ctrl;
    logic       pin_sel;
    logic       lock_s1;
    logic       lock_s2;
    logic [6:0] div_cnt;
    logic       refdiv_n;
    logic [7:0] rdata;
  } mcpc_state_type;

  localparam mcpc_state_type MCPC_STATE_RESET = '{
    ptr:      PTR_N,
    n:        N_RESET,
    m:        M_RESET,
    p:        P_RESET,
    ctrl:     CTRL_RESET,
    pin_sel:  1'b1,
    lock_s1:  1'b0,
    lock_s2:  1'b0,
    div_cnt:  7'h00,
    refdiv_n: 1'b1,
    rdata:    8'h00
  };

endpackage : mcpc_pkg

`default_nettype wire

// File: bench/mcpc_pll_model.sv
// Behavioural memory clock PLL: raises lock a fixed time after enable.
// Assumes enable and dividers come from the control block on clk.
`default_nettype none
module mcpc_pll_model
  import mcpc_pkg::*;
#(
  parameter int LOCK_DLY = 10
)(
  input  wire logic       clk,
  input  wire logic       run_enable,
  input  wire logic [5:0] n_div,
  input  wire logic [5:0] m_div,
  output logic            locked_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] n_last = '0;
  logic [5:0] m_last = '0;
  int         cnt    = 0;
  // New dividers restart acquisition, so a stale lock never survives
  always_ff @(posedge clk)
  begin
    n_last <= n_div;
    m_last <= m_div;
    if (!run_enable || n_div != n_last || m_div != m_last) cnt <= 0;
    else if (cnt < LOCK_DLY) cnt <= cnt + 1;
  end
  assign locked_raw = (cnt == LOCK_DLY);
endmodule : mcpc_pll_model
`default_nettype wire

// File: bench/tb_memory_clock_pll_control.sv
// Self-checking bench for the memory clock PLL control block.
// Assumes a 250 MHz clock and a behavioural PLL model for lock.
`default_nettype none
module tb_memory_clock_pll_control;
  timeunit 1ns;
  timeprecision 1ps;
  import mcpc_pkg::*;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, raw, en, pin, refn, lk;
  logic [7:0] reg_index = '0, reg_wdata = '0, reg_rdata, rd;
  logic [5:0] loop_n = 6'h3C, nd, md;
  logic [1:0] pd, ptr, rsel;
  logic [2:0] q;
  int fail_count = 0, compares = 0;
  mcpc_memclk_pll_control dut (.clk(clk), .srst(srst), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .memclk_pll_locked_raw(raw),
    .loop_n_value(loop_n), .pll_n_div(nd), .pll_m_div(md), .pll_p_div(pd), .pll_run_enable(en),
    .memclk_pll_locked(lk), .pll_pointer_register(ptr), .refout_source_sel(rsel),
    .memclk_pin_source_sel(pin), .loop_post_q(q), .refout_divided_n(refn));
  mcpc_pll_model pll (.clk(clk), .run_enable(en), .n_div(nd), .m_div(md), .locked_raw(raw));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    reg_index = i;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk) #1 reg_wr = 0;
    @(posedge clk) #1;
  endtask : wr
  task automatic rdr(input logic [7:0] i);
    reg_index = i;
    reg_rd = 1;
    @(posedge clk) #1 reg_rd = 0;
    rd = reg_rdata;
    @(posedge clk) #1;
  endtask : rdr
  task automatic t_reset;
    rdr(IDX_CLOCK_CONTROL);
    chk("ctrl", 8'h18, rd);
    chk("pin", 8'h01, {7'h00, pin});
    chk("ndiv", 8'h39, {2'h0, nd});
    chk("mdiv", 8'h3A, {2'h0, md});
    chk("pdiv_en", 8'h05, {5'h00, en, pd});
  endtask : t_reset
  task automatic t_program;
    int k;
    wr(IDX_PLL_POINTER, 8'h00);
    wr(IDX_MEMCLK_DATA, 8'hE8);
    wr(IDX_MEMCLK_DATA, 8'h3E);
    wr(IDX_MEMCLK_DATA, 8'h33);
    chk("ndiv", 8'h28, {2'h0, nd});
    chk("mdiv", 8'h3E, {2'h0, md});
    chk("pdiv", 8'h03, {6'h00, pd});
    chk("en", 8'h00, {7'h00, en});
    chk("lock_pin_off", 8'h00, {7'h00, lk});
    rdr(IDX_PLL_POINTER);
    chk("ptr", 8'h0C, rd);
    rdr(IDX_MEMCLK_DATA);
    chk("lock_off", 8'h00, rd & 8'h40);
    wr(IDX_PLL_POINTER, 8'h08);
    wr(IDX_MEMCLK_DATA, 8'hB3);
    chk("ptr", 8'h03, {6'h00, ptr});
    k = 0;
    do
    begin
      rdr(IDX_MEMCLK_DATA);
      k++;
    end while (rd[STATUS_LOCK_BIT] !== 1'b1 && k < 40);
    chk("lock", 8'h40, rd & 8'h40);
    chk("ptr_rd", 8'h03, {6'h00, ptr});
    chk("lock_pin", 8'h01, {7'h00, lk});
    wr(IDX_MEMCLK_DATA, 8'hFF);
    chk("ptr_wrap", 8'h00, {6'h00, ptr});
    chk("status_wr", 8'h28, {2'h0, nd});
  endtask : t_program
  task automatic t_strobe;
    // Pixel PLL is taken as already locked and driving the dot clock here
    wr(IDX_CLOCK_CONTROL, 8'h00);
    chk("pin_hold", 8'h01, {7'h00, pin});
    wr(IDX_CLOCK_CONTROL, 8'h08);
    chk("pin_dot", 8'h00, {7'h00, pin});
    wr(IDX_CLOCK_CONTROL, 8'h10);
    chk("pin_hold", 8'h00, {7'h00, pin});
    wr(IDX_CLOCK_CONTROL, 8'h18);
    chk("pin_pll", 8'h01, {7'h00, pin});
    // Pixel PLL restore happens outside this block once the pin is back
  endtask : t_strobe
  task automatic t_ctrl;
    wr(IDX_CLOCK_CONTROL, 8'hFF);
    rdr(IDX_CLOCK_CONTROL);
    chk("ctrl_rsv", 8'h7F, rd);
    chk("q", 8'h07, {5'h00, q});
    chk("refsel", 8'h03, {6'h00, rsel});
    rdr(8'h55);
    chk("unmapped", 8'h00, rd);
  endtask : t_ctrl
  task automatic t_dotn;
    int k, gap;
    wr(IDX_CLOCK_CONTROL, 8'h40);
    chk("pin_keep", 8'h01, {7'h00, pin});
    k = 0;
    while (refn !== 1'b0 && k < 200)
    begin
      @(posedge clk) #1 k++;
    end
    gap = 0;
    do
    begin
      @(posedge clk) #1 gap++;
    end while (refn !== 1'b0 && gap < 200);
    chk("dotn_gap", 8'h05, gap[7:0]);
    wr(IDX_CLOCK_CONTROL, 8'h20);
    chk("refsel", 8'h01, {6'h00, rsel});
    chk("refn_idle", 8'h01, {7'h00, refn});
  endtask : t_dotn
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1 srst = 0;
    t_reset();
    t_program();
    t_strobe();
    t_ctrl();
    t_dotn();
    print_verdict();
  end
endmodule : tb_memory_clock_pll_control
`default_nettype wire
